// ---- design/dcp_pkg.sv ----
/*
 * Constants for the DAC channel protection control block.
 * Assumes a 32-bit AHB-Lite register bus and four output channels.
 */
package dcp_pkg;
   localparam int          NUM_CH       = 4;
   // Register byte offsets
   localparam logic [2:0]  REG_SEL_PWR  = 3'h2;
   localparam logic [11:0] OFF_CTRL     = 12'h000;
   // Power register word index is its select code
   localparam logic [11:0] OFF_PWR      = {7'h00, REG_SEL_PWR, 2'h0};
   localparam logic [11:0] OFF_DATA_VLD = 12'h004;
   localparam logic [11:0] OFF_OUT      = 12'h00C;
   // Control register fields
   localparam int          CTRL_CLAMP   = 0;
   localparam int          CTRL_TSD_EN  = 1;
   localparam int          CTRL_SUP_OK  = 2;
   // Power control register fields
   localparam int          PWR_PU_LSB   = 0;
   localparam int          PWR_TSD      = 5;
   localparam int          PWR_OC_LSB   = 7;
   // Reset values
   localparam logic [2:0]  CTRL_RESET   = 3'h0;
   localparam logic [3:0]  PU_RESET     = 4'h0;
   // Timing
   localparam int          CLK_MHZ      = 25;
   localparam int          SETTLE_US    = 10;
   localparam int          SETTLE_CYC   = SETTLE_US * CLK_MHZ;
   localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
   localparam logic [2:0]  HSIZE_WORD   = 3'h2;
   typedef enum logic [1:0] {CH_OFF, CH_ON, CH_FAULT_OFF} dcp_ch_state_t;
endpackage

// ---- design/dcp_sense_if.sv ----
/*
 * Carries synchronised sensor levels between the top and the synchroniser.
 * Assumes one clock domain.
 */
`timescale 1ns/100ps
interface dcp_sense_if;
   logic [3:0] oc_sync;
   logic       ot_sync;
   modport src (output oc_sync, output ot_sync);
   modport dst (input  oc_sync, input  ot_sync);
endinterface

// ---- design/dcp_sync.sv ----
/*
 * Two-flop synchronisers for the analog overcurrent and temperature flags.
 * Assumes sensor levels are asynchronous to hclk.
 */
`timescale 1ns/100ps
module dcp_sync (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [3:0] oc_async,
   input  wire logic       ot_async,
   dcp_sense_if.src        sense
);
   logic [4:0] meta_reg;
   logic [4:0] sync_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= 5'h00;
         sync_reg <= 5'h00;
      end else begin
         meta_reg <= {ot_async, oc_async};
         sync_reg <= meta_reg;
      end
   end

   assign sense.oc_sync = sync_reg[3:0];
   assign sense.ot_sync = sync_reg[4];
endmodule

// ---- design/dcp_top.sv ----
/*
 * Power state, overcurrent policy and thermal shutdown control for a quad
 * voltage-output DAC, with an AHB-Lite register slave.
 * Assumes one 25 MHz clock and sensor levels from the analog front end.
 */
`timescale 1ns/100ps
module dcp_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [3:0]  oc_detect,
   input  wire logic        over_temp,
   output logic      [3:0]  amplifier_connect_gate,
   output logic      [3:0]  output_ground_clamp_gate,
   output logic      [3:0]  current_limit_en
);
   dcp_sense_if sense ();

   logic                  wr_pend_reg;
   logic [11:0]           addr_reg;
   logic [2:0]            ctrl_reg;
   logic [3:0]            pu_reg;
   logic [3:0]            oc_reg;
   logic                  tsd_reg;
   logic [3:0]            data_vld_reg;
   logic [3:0]            fault_pend_reg;
   logic [3:0]            pu_next;
   logic [31:0]           rd_next;
   logic                  acc_ok;
   logic                  wr_ctrl;
   logic                  wr_pwr;
   logic                  wr_data;
   logic                  thermal_trip;
   dcp_pkg::dcp_ch_state_t st [dcp_pkg::NUM_CH];

   localparam logic PU_RESET_BIT = dcp_pkg::PU_RESET[0];

   dcp_sync u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .oc_async (oc_detect),
      .ot_async (over_temp),
      .sense    (sense.src)
   );

   // ***************************************************
   // AHB-Lite slave
   // ***************************************************
   assign acc_ok  = hsel && hready && (htrans == dcp_pkg::HTRANS_NSEQ)
                    && (hsize == dcp_pkg::HSIZE_WORD);
   assign wr_ctrl = wr_pend_reg && (addr_reg == dcp_pkg::OFF_CTRL);
   assign wr_pwr  = wr_pend_reg && (addr_reg == dcp_pkg::OFF_PWR);
   assign wr_data = wr_pend_reg && (addr_reg == dcp_pkg::OFF_DATA_VLD);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         addr_reg    <= 12'h000;
      end else begin
         wr_pend_reg <= acc_ok && hwrite;
         if (acc_ok) begin
            addr_reg <= haddr;
         end
      end
   end

   always_comb begin
      rd_next = 32'h0000_0000;
      case (haddr)
         dcp_pkg::OFF_CTRL: begin
            rd_next[2:0] = ctrl_reg;
         end
         dcp_pkg::OFF_PWR: begin
            rd_next[dcp_pkg::PWR_PU_LSB +: 4] = pu_next;
            rd_next[dcp_pkg::PWR_TSD]         = tsd_reg;
            rd_next[dcp_pkg::PWR_OC_LSB +: 4] = oc_reg;
         end
         dcp_pkg::OFF_DATA_VLD: begin
            rd_next[3:0] = data_vld_reg;
         end
         dcp_pkg::OFF_OUT: begin
            rd_next[3:0] = amplifier_connect_gate;
         end
         default: begin
            rd_next = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (acc_ok && !hwrite) begin
            hrdata <= rd_next;
         end
      end
   end

   // ***************************************************
   // Control and data-valid registers
   // ***************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= dcp_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= hwdata[2:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_vld_reg <= 4'h0;
      end else if (wr_data) begin
         data_vld_reg <= data_vld_reg | hwdata[3:0];
      end
   end

   // ***************************************************
   // Protection flags
   // ***************************************************
   assign thermal_trip = ctrl_reg[dcp_pkg::CTRL_TSD_EN] && sense.ot_sync;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tsd_reg <= 1'b0;
      end else if (thermal_trip) begin
         tsd_reg <= 1'b1;
      end
   end

   // ***************************************************
   // Per-channel power state
   // ***************************************************
   genvar ch;
   generate
      for (ch = 0; ch < dcp_pkg::NUM_CH; ch++) begin : g_ch
         logic oc_now;
         logic pu_wr;
         assign oc_now = sense.oc_sync[ch];
         assign pu_wr  = wr_pwr && hwdata[dcp_pkg::PWR_PU_LSB + ch];

         // Current limit flag tracks short; power-down flag is sticky
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               oc_reg[ch] <= 1'b0;
            end else if (ctrl_reg[dcp_pkg::CTRL_CLAMP]) begin
               oc_reg[ch] <= oc_now;
            end else if (oc_now) begin
               oc_reg[ch] <= 1'b1;
            end else if (pu_wr) begin
               oc_reg[ch] <= 1'b0;
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               fault_pend_reg[ch] <= 1'b0;
            end else begin
               fault_pend_reg[ch] <= oc_now
                  && !ctrl_reg[dcp_pkg::CTRL_CLAMP];
            end
         end

         always_comb begin
            pu_next[ch] = pu_reg[ch];
            if (wr_pwr) begin
               pu_next[ch] = hwdata[dcp_pkg::PWR_PU_LSB + ch];
            end
            if (thermal_trip || fault_pend_reg[ch]) begin
               pu_next[ch] = 1'b0;
            end
         end

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pu_reg[ch] <= PU_RESET_BIT;
            end else begin
               pu_reg[ch] <= pu_next[ch];
            end
         end

         always_comb begin
            if (pu_reg[ch]) begin
               st[ch] = dcp_pkg::CH_ON;
            end else if (oc_reg[ch]) begin
               st[ch] = dcp_pkg::CH_FAULT_OFF;
            end else begin
               st[ch] = dcp_pkg::CH_OFF;
            end
         end

         // Amplifier connects only when powered, supplied and loaded
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               amplifier_connect_gate[ch]   <= 1'b0;
               output_ground_clamp_gate[ch] <= 1'b1;
               current_limit_en[ch]         <= 1'b0;
            end else begin
               case (st[ch])
                  dcp_pkg::CH_ON: begin
                     amplifier_connect_gate[ch] <= data_vld_reg[ch]
                        && ctrl_reg[dcp_pkg::CTRL_SUP_OK];
                     output_ground_clamp_gate[ch] <= !(data_vld_reg[ch]
                        && ctrl_reg[dcp_pkg::CTRL_SUP_OK]);
                  end
                  default: begin
                     amplifier_connect_gate[ch]   <= 1'b0;
                     output_ground_clamp_gate[ch] <= 1'b1;
                  end
               endcase
               current_limit_en[ch] <= oc_now
                  && ctrl_reg[dcp_pkg::CTRL_CLAMP];
            end
         end
      end
   endgenerate
endmodule

// ---- verif/dcp_host.sv ----
/* Host model: AHB-Lite master of single word transfers.
   Assumes one slave whose hreadyout is wired back as hready. */
`timescale 1ns/100ps
module dcp_host (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel = 1'b0,
   output logic      [11:0] haddr = 12'h000,
   output logic      [1:0]  htrans = 2'h0,
   output logic             hwrite = 1'b0,
   output logic      [2:0]  hsize = 3'h0,
   output logic      [31:0] hwdata = 32'h0000_0000,
   output logic             hang = 1'b0
);
   // Address phase, then data phase; both held until hready
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= dcp_pkg::HTRANS_NSEQ;
      hwrite <= w;
      hsize <= dcp_pkg::HSIZE_WORD;
      do @(posedge hclk); while (hready !== 1'b1 && ++n < 64);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1 && ++n < 64);
      q = hrdata;
      if (n >= 64)
         hang <= 1'b1;
   endtask
endmodule

// ---- verif/dcp_chk.sv ----
/* Port checker for the protection control block.
   Assumes it is bound onto dcp_top and sees its ports only. */
`timescale 1ns/100ps
module dcp_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [3:0]  oc_detect,
   input wire logic        over_temp,
   input wire logic [3:0]  amplifier_connect_gate,
   input wire logic [3:0]  output_ground_clamp_gate,
   input wire logic [3:0]  current_limit_en
);
   // ****
   // Shadow of the control register
   // ****
   logic       wr_ph;
   logic [2:0] ctrl;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph <= 1'b0;
         ctrl <= dcp_pkg::CTRL_RESET;
      end else begin
         wr_ph <= hsel && hready && htrans == dcp_pkg::HTRANS_NSEQ
                  && hwrite && hsize == dcp_pkg::HSIZE_WORD
                  && haddr == dcp_pkg::OFF_CTRL;
         if (wr_ph)
            ctrl <= hwdata[2:0];
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_rst;
      $rose(hresetn) |-> amplifier_connect_gate == 4'h0
                         && output_ground_clamp_gate == 4'hf;
   endproperty
   a_rst: assert property (p_rst) else $error("gates after reset");
   property p_cmp;
      output_ground_clamp_gate == ~amplifier_connect_gate;
   endproperty
   a_cmp: assert property (p_cmp) else $error("clamp vs amp");
   property p_sup;
      (!ctrl[2]) [*4] |-> amplifier_connect_gate == 4'h0;
   endproperty
   a_sup: assert property (p_sup) else $error("amp without supply");
   property p_nolim;
      (!ctrl[0]) [*3] |-> current_limit_en == 4'h0;
   endproperty
   a_nolim: assert property (p_nolim) else $error("limit in auto");
   property p_lim;
      (ctrl[0] && $stable(oc_detect)) [*5] |-> current_limit_en == oc_detect;
   endproperty
   a_lim: assert property (p_lim) else $error("limit vs short");
   property p_auto;
      (!ctrl[0] && $stable(oc_detect)) [*7] |->
         (amplifier_connect_gate & $past(amplifier_connect_gate)
          & oc_detect) == 4'h0;
   endproperty
   a_auto: assert property (p_auto) else $error("short kept on");
   property p_tsd;
      (ctrl[1] && over_temp) [*7] |-> amplifier_connect_gate == 4'h0;
   endproperty
   a_tsd: assert property (p_tsd) else $error("hot channel on");
   property p_rdy;
      hreadyout == 1'b1;
   endproperty
   a_rdy: assert property (p_rdy) else $error("wait state");
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
endmodule
bind dcp_top dcp_chk chk_u (.*);

// ---- verif/test_dac_channel_protection_ctrl.sv ----
/* Self-checking bench for the protection control block.
   Assumes dcp_host as bus master and dcp_chk bound to the top. */
`timescale 1ns/100ps
module test_dac_channel_protection_ctrl;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic [3:0]  oc_detect = 4'h0;
   logic        over_temp = 1'b0;
   logic        hsel, hwrite, hready, hreadyout, hresp, hang;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata;
   logic [3:0]  amplifier_connect_gate, output_ground_clamp_gate;
   logic [3:0]  current_limit_en;
   int          n_mismatch = 0;
   int          checks = 0;
   assign hready = hreadyout;
   dcp_top dut_u (.*);
   dcp_host host_u (.*);
   initial begin
      forever #20 hclk = ~hclk;
   end
   // ****
   // Compare and bus helpers
   // ****
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp32(input logic [11:0] a, input logic [31:0] e,
                        input logic [31:0] s);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD reg %h expected %h seen %h", a, e, s);
      end
   endtask
   task automatic cmp4(input string nm, input logic [3:0] e,
                       input logic [3:0] s);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      host_u.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      host_u.xfer(1'b0, a, 32'h0000_0000, q);
      cmp32(a, e, q);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask
   always @(posedge hang) begin
      n_mismatch++;
      conclude;
   end
   // ****
   // Scenarios
   // ****
   task automatic s_reset;
      cmp4("amp", 4'h0, amplifier_connect_gate);
      cmp4("clamp", 4'hf, output_ground_clamp_gate);
      rd(dcp_pkg::OFF_CTRL, 32'h0000_0000);
      rd(dcp_pkg::OFF_PWR, 32'h0000_0000);
   endtask
   task automatic s_power;
      wr(dcp_pkg::OFF_CTRL, 32'h0000_0004);
      wr(dcp_pkg::OFF_PWR, 32'h0000_07af);
      idle(dcp_pkg::SETTLE_CYC);
      cmp4("amp", 4'h0, amplifier_connect_gate);
      rd(dcp_pkg::OFF_PWR, 32'h0000_000f);
      wr(dcp_pkg::OFF_DATA_VLD, 32'h0000_000f);
      idle(3);
      cmp4("clamp", 4'h0, output_ground_clamp_gate);
      rd(dcp_pkg::OFF_OUT, 32'h0000_000f);
      rd(12'h010, 32'h0000_0000);
   endtask
   task automatic s_clamp;
      wr(dcp_pkg::OFF_CTRL, 32'h0000_0005);
      oc_detect <= 4'h2;
      idle(6);
      cmp4("lim", 4'h2, current_limit_en);
      cmp4("amp", 4'hf, amplifier_connect_gate);
      rd(dcp_pkg::OFF_PWR, 32'h0000_010f);
      oc_detect <= 4'h0;
      idle(6);
      rd(dcp_pkg::OFF_PWR, 32'h0000_000f);
   endtask
   task automatic s_auto;
      wr(dcp_pkg::OFF_CTRL, 32'h0000_0004);
      oc_detect <= 4'h1;
      idle(8);
      cmp4("amp", 4'he, amplifier_connect_gate);
      cmp4("lim", 4'h0, current_limit_en);
      rd(dcp_pkg::OFF_PWR, 32'h0000_008e);
      wr(dcp_pkg::OFF_PWR, 32'h0000_000f);
      idle(2);
      rd(dcp_pkg::OFF_PWR, 32'h0000_008e);
      oc_detect <= 4'h0;
      idle(6);
      wr(dcp_pkg::OFF_PWR, 32'h0000_000f);
      idle(dcp_pkg::SETTLE_CYC);
      cmp4("amp", 4'hf, amplifier_connect_gate);
      rd(dcp_pkg::OFF_PWR, 32'h0000_000f);
   endtask
   task automatic s_thermal;
      over_temp <= 1'b1;
      idle(8);
      cmp4("amp", 4'hf, amplifier_connect_gate);
      wr(dcp_pkg::OFF_CTRL, 32'h0000_0006);
      idle(8);
      cmp4("amp", 4'h0, amplifier_connect_gate);
      over_temp <= 1'b0;
      idle(6);
      rd(dcp_pkg::OFF_PWR, 32'h0000_0020);
   endtask
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      s_reset;
      s_power;
      s_clamp;
      s_auto;
      s_thermal;
      conclude;
   end
endmodule
